// file: timer_regs.svh
// Register indices, reset values and timing constants of the timer.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register indices; the byte address is four times the index.
`define IDX_CNT_HI   12'hf00
`define IDX_CNT_LO   12'hf01
`define IDX_RLD_HI   12'hf02
`define IDX_RLD_LO   12'hf03
`define IDX_PWM_HI   12'hf04
`define IDX_PWM_LO   12'hf05
`define IDX_CTL0     12'hf06
`define IDX_CTL1     12'hf07
`define IDX_STAT     12'hf08
`define IDX_MASK     12'hf09

// Reset values, and the count restart value after a reload.
`define RST_BYTE     8'h00
`define RST_CNT      16'h0000
`define RST_RELOAD   16'hffff
`define RST_PWM      16'h0000
`define CNT_RESTART  16'h0001

// Writable bits of control register zero; the rest read as zero.
`define CTL0_MASK    8'h61

// Status and mask bit positions.
`define ST_RELOAD    0
`define ST_INPUT     1

// Interrupt source selections.
`define SRC_BOTH     2'h0
`define SRC_INPUT    2'h1
`define SRC_RELOAD   2'h2

// System clock period.
`define CLK_PERIOD_NS 10

`endif

// file: timer_pkg.sv
// Types shared by the timer: modes, control layouts and run states.
package timer_pkg;

	typedef enum logic [2:0] {
		MODE_COMPARE = 3'h0,
		MODE_GATED   = 3'h1,
		MODE_CAPTURE = 3'h2,
		MODE_CAPCMP  = 3'h3,
		MODE_PWM     = 3'h4
	} mode_t;

	typedef struct packed {
		logic       enable;
		logic       polarity;
		mode_t      mode;
		logic [2:0] prescale;
	} ctl_one_t;

	typedef struct packed {
		logic       rsvd_hi;
		logic [1:0] int_src;
		logic [3:0] rsvd_lo;
		logic       out_enable;
	} ctl_zero_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARM  = 3'b010,
		ST_RUN  = 3'b100
	} run_state_t;

endpackage

// file: reload_timer.sv
// Reloadable 16-bit timer with prescaler, gate, capture and PWM output.
`timescale 1ns/1ps
//
// Contract
// - Compare mode counts system clock, ignores pin.
// - Counter advances once per prescaled tick.
// - Gated mode counts only while input active.
// - Gated mode interrupts on deassertion or reload.
// - At reload value: interrupt, restart 0001h.
// - Reload toggles output when output enabled, except in PWM mode.
// - Interrupt source field restricts capture/reload events.
// - First qualifying edge starts count, no interrupt.
// - Capture value reflects prescaled elapsed count.
// - Count reads never disturb timer operation.
// - High-byte read latches low byte for later.
// - Disabled timer: low read returns live count.
// - PWM match against count changes PWM output.
// - Polarity bit sets PWM output level.
// - Capture modes store count in PWM registers.

`include "timer_regs.svh"

module reload_timer
	import timer_pkg::*;
#(
	parameter int PRESC_MAX = 7
)(
	// Clock, reset and clock enable
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	input  wire logic        enable_i,
	// Avalon-MM slave
	input  wire logic [13:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Timer pins
	input  wire logic        timer_in_i,
	output logic             timer_out_o,
	output logic             timer_out_en_o,
	// Interrupt
	output logic             irq_o
);

	if (PRESC_MAX < 0 || PRESC_MAX > 7) begin : g_chk
		$error("PRESC_MAX must lie between 0 and 7");
	end

	////////////////////////////////////////////////////////////////////////
	// State.
	logic [15:0] cnt_ff;
	logic [15:0] reload_ff;
	logic [15:0] pwm_ff;
	logic [7:0]  hold_ff;
	ctl_zero_t   ctl0_ff;
	ctl_one_t    ctl1_ff;
	logic [1:0]  status_ff;
	logic [1:0]  mask_ff;
	logic [6:0]  presc_ff;
	run_state_t  st_ff;
	logic [2:0]  sync_ff;
	logic        in_level_ff;
	logic        active_prev_ff;
	logic        out_ff;
	logic        ack_ff;
	logic [7:0]  rdata_ff;
	logic [15:0] nxt_cnt;
	logic [15:0] nxt_pwm;
	logic        nxt_out;
	run_state_t  nxt_st;

	////////////////////////////////////////////////////////////////////////
	// Bus decode. Every access takes one wait state.
	wire        bus_req  = avs_read_i | avs_write_i;
	wire [11:0] idx      = avs_address_i[13:2];
	wire [7:0]  wbyte    = avs_writedata_i[7:0];
	wire        wr_take  = avs_write_i & ack_ff & avs_byteenable_i[0];
	wire        rd_first = avs_read_i & ~ack_ff;

	wire sel_cnt_hi = (idx == `IDX_CNT_HI);
	wire sel_cnt_lo = (idx == `IDX_CNT_LO);
	wire sel_rld_hi = (idx == `IDX_RLD_HI);
	wire sel_rld_lo = (idx == `IDX_RLD_LO);
	wire sel_pwm_hi = (idx == `IDX_PWM_HI);
	wire sel_pwm_lo = (idx == `IDX_PWM_LO);
	wire sel_ctl0   = (idx == `IDX_CTL0);
	wire sel_ctl1   = (idx == `IDX_CTL1);
	wire sel_stat   = (idx == `IDX_STAT);
	wire sel_mask   = (idx == `IDX_MASK);

	wire cnt_hi_wr = wr_take & sel_cnt_hi;
	wire cnt_lo_wr = wr_take & sel_cnt_lo;
	wire cnt_wr    = cnt_hi_wr | cnt_lo_wr;
	wire pwm_hi_wr = wr_take & sel_pwm_hi;
	wire pwm_lo_wr = wr_take & sel_pwm_lo;
	wire stat_wr   = wr_take & sel_stat;
	// A frozen clock enable keeps the master waiting, so no write is lost.
	assign avs_waitrequest_o = bus_req & ~(ack_ff & enable_i);
	assign avs_readdata_o    = {24'h000000, rdata_ff};

	////////////////////////////////////////////////////////////////////////
	// Control decode.
	wire   timer_en = ctl1_ff.enable;
	wire   pol      = ctl1_ff.polarity;
	mode_t mode;
	assign mode = ctl1_ff.mode;
	wire is_gated = (mode == MODE_GATED);
	wire is_pwm   = (mode == MODE_PWM);
	wire is_cap   = (mode == MODE_CAPTURE) | (mode == MODE_CAPCMP);
	// The pin is asserted while its level equals the polarity bit, so
	// software tells a deassertion interrupt by the same comparison.
	wire in_active  = (in_level_ff == pol);
	wire qual_edge  = in_active & ~active_prev_ff;
	wire deassert   = ~in_active & active_prev_ff;
	wire [2:0] presc_exp = (ctl1_ff.prescale > 3'(PRESC_MAX)) ?
		3'(PRESC_MAX) : ctl1_ff.prescale;
	wire [7:0] presc_span = 8'h01 << presc_exp;
	wire [6:0] presc_last = 7'(presc_span - 8'h01);

	////////////////////////////////////////////////////////////////////////
	// Counting.
	wire running   = (st_ff == ST_RUN);
	// The gate only matters in gated mode; every other mode counts the
	// system clock through the prescaler.
	wire count_en  = running & (~is_gated | in_active);
	wire tick      = (presc_ff == presc_last);
	wire step      = count_en & tick;
	wire at_reload = (cnt_ff == reload_ff);
	wire reload_ev = step & at_reload;
	wire cap_ev    = running & is_cap & qual_edge;
	wire gate_ev   = running & is_gated & deassert;
	wire input_ev  = cap_ev | gate_ev;
	wire pwm_match = step & is_pwm & ~at_reload & (cnt_ff == pwm_ff);

	// Interrupt source restriction; the fourth code behaves as both.
	wire set_rld = reload_ev & (ctl0_ff.int_src != `SRC_INPUT);
	wire set_inp = input_ev & (ctl0_ff.int_src != `SRC_RELOAD);
	wire [1:0] stat_set = {set_inp, set_rld};
	wire [1:0] stat_clr = stat_wr ? wbyte[1:0] : 2'h0;
	assign irq_o          = |(status_ff & mask_ff);
	assign timer_out_o    = out_ff;
	assign timer_out_en_o = ctl0_ff.out_enable;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (cnt_hi_wr) begin
			nxt_cnt[15:8] = wbyte;
		end else if (cnt_lo_wr) begin
			nxt_cnt[7:0] = wbyte;
		end else if (reload_ev) begin
			nxt_cnt = `CNT_RESTART;
		end else if (cap_ev && mode == MODE_CAPCMP) begin
			nxt_cnt = `CNT_RESTART;
		end else if (step) begin
			nxt_cnt = cnt_ff + 16'h0001;
		end
	end
	// A capture beats a software write in the same cycle.
	always_comb begin
		nxt_pwm = pwm_ff;
		if (cap_ev) begin
			nxt_pwm = cnt_ff;
		end else if (pwm_hi_wr) begin
			nxt_pwm[15:8] = wbyte;
		end else if (pwm_lo_wr) begin
			nxt_pwm[7:0] = wbyte;
		end
	end
	always_comb begin
		nxt_out = out_ff;
		if (is_pwm && reload_ev) begin
			nxt_out = pol;
		end else if (pwm_match) begin
			nxt_out = ~pol;
		end else if (reload_ev && ctl0_ff.out_enable) begin
			nxt_out = ~out_ff;
		end
	end
	// Capture modes wait in ST_ARM for the first edge, which starts the
	// count but raises no event.
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: begin
				if (timer_en) begin
					nxt_st = is_cap ? ST_ARM : ST_RUN;
				end
			end
			ST_ARM: begin
				if (!timer_en) begin
					nxt_st = ST_IDLE;
				end else if (qual_edge) begin
					nxt_st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!timer_en) begin
					nxt_st = ST_IDLE;
				end
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Read data. Low-byte reads of a running timer return the byte held
	// by the last high-byte read, so both halves come from one instant.
	wire [7:0] cnt_lo_rd = timer_en ? hold_ff : cnt_ff[7:0];
	wire [7:0] rd_byte =
		({8{sel_cnt_hi}} & cnt_ff[15:8]) |
		({8{sel_cnt_lo}} & cnt_lo_rd) |
		({8{sel_rld_hi}} & reload_ff[15:8]) |
		({8{sel_rld_lo}} & reload_ff[7:0]) |
		({8{sel_pwm_hi}} & pwm_ff[15:8]) |
		({8{sel_pwm_lo}} & pwm_ff[7:0]) |
		({8{sel_ctl0}}   & 8'(ctl0_ff)) |
		({8{sel_ctl1}}   & 8'(ctl1_ff)) |
		({8{sel_stat}}   & {6'h00, status_ff}) |
		({8{sel_mask}}   & {6'h00, mask_ff});

	////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_ff   <= 1'b0;
			rdata_ff <= `RST_BYTE;
			hold_ff  <= `RST_BYTE;
		end else if (enable_i) begin
			ack_ff <= bus_req & ~ack_ff;
			if (rd_first) begin
				rdata_ff <= rd_byte;
			end
			if (rd_first && sel_cnt_hi && timer_en) begin
				hold_ff <= cnt_ff[7:0];
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reload_ff <= `RST_RELOAD;
			ctl0_ff   <= ctl_zero_t'(`RST_BYTE);
			ctl1_ff   <= ctl_one_t'(`RST_BYTE);
			mask_ff   <= 2'h0;
		end else if (enable_i && wr_take) begin
			if (sel_rld_hi) begin
				reload_ff[15:8] <= wbyte;
			end
			if (sel_rld_lo) begin
				reload_ff[7:0] <= wbyte;
			end
			if (sel_ctl0) begin
				ctl0_ff <= ctl_zero_t'(wbyte & `CTL0_MASK);
			end
			if (sel_ctl1) begin
				ctl1_ff <= ctl_one_t'(wbyte);
			end
			if (sel_mask) begin
				mask_ff <= wbyte[1:0];
			end
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_ff    <= `RST_CNT;
			pwm_ff    <= `RST_PWM;
			out_ff    <= 1'b0;
			st_ff     <= ST_IDLE;
			status_ff <= 2'h0;
		end else if (enable_i) begin
			cnt_ff    <= nxt_cnt;
			pwm_ff    <= nxt_pwm;
			out_ff    <= nxt_out;
			st_ff     <= nxt_st;
			status_ff <= (status_ff & ~stat_clr) | stat_set;
		end
	end

	// The prescaler restarts whenever the count is stopped, so each
	// run begins with a whole prescale period.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			presc_ff <= 7'h00;
		end else if (enable_i) begin
			if (!count_en || tick) begin
				presc_ff <= 7'h00;
			end else begin
				presc_ff <= presc_ff + 7'h01;
			end
		end
	end

	// Input pin: three stages, a change counts once stages two and three
	// agree. Changing the polarity bit may look like an edge.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync_ff        <= 3'h0;
			in_level_ff    <= 1'b0;
			active_prev_ff <= 1'b0;
		end else if (enable_i) begin
			sync_ff <= {sync_ff[1:0], timer_in_i};
			if (sync_ff[1] == sync_ff[2]) begin
				in_level_ff <= sync_ff[2];
			end
			active_prev_ff <= in_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);
	property p_compare_clock;
		enable_i && running && mode == MODE_COMPARE && tick &&
			!at_reload && !cnt_wr
		|=> cnt_ff == $past(cnt_ff) + 16'h0001;
	endproperty
	a_compare_clock: assert property (p_compare_clock)
		else $error("compare mode count did not advance");
	property p_prescale;
		enable_i && !tick && !cnt_wr && !cap_ev |=> $stable(cnt_ff);
	endproperty
	a_prescale: assert property (p_prescale)
		else $error("count moved between prescaled ticks");
	property p_gate_hold;
		enable_i && is_gated && !in_active && !cnt_wr
		|=> cnt_ff == $past(cnt_ff);
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gated count moved while input inactive");
	property p_reload_restart;
		enable_i && reload_ev && !cnt_wr && !stat_wr &&
			ctl0_ff.int_src != `SRC_INPUT
		|=> cnt_ff == `CNT_RESTART && status_ff[`ST_RELOAD];
	endproperty
	a_reload_restart: assert property (p_reload_restart)
		else $error("reload did not restart count and flag");
	property p_gate_irq;
		enable_i && gate_ev && ctl0_ff.int_src == `SRC_BOTH
		|=> status_ff[`ST_INPUT];
	endproperty
	a_gate_irq: assert property (p_gate_irq)
		else $error("gate deassertion raised no event");
	property p_out_toggle;
		enable_i && reload_ev && !is_pwm && ctl0_ff.out_enable
		|=> out_ff != $past(out_ff);
	endproperty
	a_out_toggle: assert property (p_out_toggle)
		else $error("output did not toggle on reload");
	property p_src_reload_only;
		enable_i && ctl0_ff.int_src == `SRC_RELOAD &&
			!status_ff[`ST_INPUT]
		|=> !status_ff[`ST_INPUT];
	endproperty
	a_src_reload_only: assert property (p_src_reload_only)
		else $error("input event flagged while restricted");
	property p_first_edge;
		enable_i && st_ff == ST_ARM && timer_en && qual_edge && !stat_wr
		|=> st_ff == ST_RUN && status_ff == $past(status_ff);
	endproperty
	a_first_edge: assert property (p_first_edge)
		else $error("first edge did not start or raised event");
	property p_hold_latch;
		enable_i && rd_first && sel_cnt_hi && timer_en
		|=> hold_ff == $past(cnt_ff[7:0]);
	endproperty
	a_hold_latch: assert property (p_hold_latch)
		else $error("high read did not latch low byte");
	property p_live_low;
		enable_i && rd_first && sel_cnt_lo && !timer_en
		|=> avs_readdata_o[7:0] == $past(cnt_ff[7:0]);
	endproperty
	a_live_low: assert property (p_live_low)
		else $error("disabled low read not live count");
	property p_capture;
		enable_i && cap_ev |=> pwm_ff == $past(cnt_ff);
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture did not store count");
	property p_pwm_match;
		enable_i && pwm_match |=> out_ff == !$past(pol);
	endproperty
	a_pwm_match: assert property (p_pwm_match)
		else $error("pwm match did not set output");

endmodule

// file: timer_pin_model.sv
// Behavioural model of the pin driver on the timer's far side.
`timescale 1ns/1ps
module timer_pin_model (
	// Clock
	input  wire logic clock_i,
	// Requests from the bench
	input  wire logic level_i,
	input  wire logic noise_i,
	// Timer input pin
	output logic      timer_in_o
);
	initial timer_in_o = 1'b0;
	// Noise is unrelated pin traffic that compare mode must not see.
	always @(posedge clock_i) begin
		timer_in_o <= noise_i ? ~timer_in_o : level_i;
	end
endmodule

// file: reloadable_timer_pwm_capture_tb_top.sv
// Self-checking bench of the reloadable timer.
`timescale 1ns/1ps
`include "timer_regs.svh"
module reloadable_timer_pwm_capture_tb_top
	import timer_pkg::*;
;
	logic        clock_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [13:0] addr = '0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0]  be = 4'h1;
	logic [31:0] rdata;
	logic        wait_o;
	logic        tout;
	logic        toen;
	logic        irq;
	logic        tin;
	logic        lvl = 1'b0;
	logic        noise = 1'b0;
	logic        ce = 1'b1;
	int          fail_count = 0;
	int          checks_done = 0;
	logic [31:0] seed = 32'hbf1b0642;

	always #5 clock_i = ~clock_i;

	reload_timer i_reload_timer (
		.clock_i          (clock_i),
		.resetn_i         (resetn_i),
		.enable_i         (ce),
		.avs_address_i    (addr),
		.avs_read_i       (rd),
		.avs_write_i      (wr),
		.avs_writedata_i  (wdata),
		.avs_byteenable_i (be),
		.avs_readdata_o   (rdata),
		.avs_waitrequest_o(wait_o),
		.timer_in_i       (tin),
		.timer_out_o      (tout),
		.timer_out_en_o   (toen),
		.irq_o            (irq)
	);

	timer_pin_model i_timer_pin_model (
		.clock_i   (clock_i),
		.level_i   (lvl),
		.noise_i   (noise),
		.timer_in_o(tin)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] c1(logic en, logic pol, mode_t m,
			logic [2:0] p);
		return {en, pol, m, p};
	endfunction

	function automatic logic [7:0] c0(logic [1:0] src, logic oe);
		return {1'b0, src, 4'h0, oe};
	endfunction

	// Count after n steps from c; a step at the reload value gives 0001.
	function automatic logic [15:0] steps(logic [15:0] c, r, int n);
		return (c + n > r) ? 16'(c + n - r) : 16'(c + n);
	endfunction

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tmo(string w);
		fail_count++;
		$display("ERROR %0t timeout in %s", $time, w);
		stop_test();
	endtask

	task automatic check(logic [15:0] got, exp, string w);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s: got %h want %h", $time, w, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// The request is held until the edge that sees waitrequest low.
	task automatic bus(logic w, logic [11:0] i, logic [7:0] d,
			output logic [7:0] q);
		int n;
		@(posedge clock_i);
		addr  <= {i, 2'b00};
		wdata <= {24'h0, d};
		rd    <= ~w;
		wr    <= w;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
			if (n > 50) tmo("bus");
		end while (wait_o !== 1'b0);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wr_reg(logic [11:0] i, logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, q);
	endtask

	task automatic rd_chk(logic [11:0] i, logic [7:0] e, string w);
		logic [7:0] q;
		bus(1'b0, i, 8'h00, q);
		check(16'(q), 16'(e), w);
	endtask

	task automatic rd16(logic [11:0] hi, output logic [15:0] v);
		bus(1'b0, hi, 8'h00, v[15:8]);
		bus(1'b0, hi + 12'h1, 8'h00, v[7:0]);
	endtask

	task automatic wait_out(logic v, output int n);
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
			if (n > 5000) tmo("pin");
		end while (tout !== v);
	endtask

	task automatic setup(logic [15:0] cnt, rl, logic [7:0] c0v, mk);
		wr_reg(`IDX_CTL1, 8'h00);
		wr_reg(`IDX_CNT_HI, cnt[15:8]);
		wr_reg(`IDX_CNT_LO, cnt[7:0]);
		wr_reg(`IDX_RLD_HI, rl[15:8]);
		wr_reg(`IDX_RLD_LO, rl[7:0]);
		wr_reg(`IDX_MASK, mk);
		wr_reg(`IDX_CTL0, c0v);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  d;
		logic [15:0] v1, v2, r, m;
		int          k, p, a;
		repeat (4) @(posedge clock_i);
		resetn_i <= 1'b1;
		// Register table: reset values, read-write, refused writes.
		rd_chk(`IDX_PWM_HI, 8'h00, "pwm hi reset");
		rd_chk(`IDX_PWM_LO, 8'h00, "pwm lo reset");
		d = 8'(rnd());
		wr_reg(`IDX_PWM_HI, d);
		wr_reg(`IDX_PWM_LO, ~d);
		rd_chk(`IDX_PWM_HI, d, "pwm hi rw");
		rd_chk(`IDX_PWM_LO, ~d, "pwm lo rw");
		be <= 4'h0;
		wr_reg(`IDX_PWM_LO, d);
		be <= 4'h1;
		rd_chk(`IDX_PWM_LO, ~d, "byteenable off");
		rd_chk(12'hf0a, 8'h00, "unmapped");
		wr_reg(`IDX_CTL0, 8'hff);
		rd_chk(`IDX_CTL0, `CTL0_MASK, "ctl0 reserved");
		$display("Test registers done");
		// Disabled: the low byte reads live, no holding.
		wr_reg(`IDX_CNT_HI, 8'h12);
		wr_reg(`IDX_CNT_LO, 8'h34);
		rd_chk(`IDX_CNT_HI, 8'h12, "count hi");
		wr_reg(`IDX_CNT_LO, 8'h56);
		rd_chk(`IDX_CNT_LO, 8'h56, "live low");
		// Enabled: a pause between the byte reads must not show.
		setup(16'h0100, 16'hffff, 8'h00, 8'h00);
		wr_reg(`IDX_CTL1, c1(1'b1, 1'b0, MODE_COMPARE, 3'h0));
		k = rnd() % 100 + 10;
		bus(1'b0, `IDX_CNT_HI, 8'h00, v1[15:8]);
		repeat (k) @(posedge clock_i);
		bus(1'b0, `IDX_CNT_LO, 8'h00, v1[7:0]);
		rd16(`IDX_CNT_HI, v2);
		check(v2 - v1, 16'(k + 6), "held low byte");
		// A low clock enable freezes the count and the bus alike.
		rd16(`IDX_CNT_HI, v1);
		ce <= 1'b0;
		repeat (20) @(posedge clock_i);
		ce <= 1'b1;
		rd16(`IDX_CNT_HI, v2);
		check(v2 - v1, 16'h0006, "clock enable freeze");
		$display("Test count read done");
		// Compare: clock counts, the pin is ignored, reload toggles out.
		noise <= 1'b1;
		p = rnd() % 3;
		r = 16'(rnd() % 32 + 8);
		setup(16'h0001, r, c0(2'h0, 1'b1), 8'h01);
		wr_reg(`IDX_CTL1, c1(1'b1, 1'b0, MODE_COMPARE, 3'(p)));
		wait_out(~tout, k);
		wait_out(~tout, k);
		check(16'(k), r << p, "reload period");
		check(16'(toen), 16'h1, "out enable");
		check(16'(irq), 16'h1, "reload irq");
		wr_reg(`IDX_CTL1, 8'h00);
		wr_reg(`IDX_STAT, 8'h03);
		@(posedge clock_i);
		check(16'(irq), 16'h0, "irq cleared");
		noise <= 1'b0;
		$display("Test compare done");
		// Gated: counts only while the pin is high, per source field.
		for (int s = 0; s < 4; s++) begin
			lvl <= 1'b0;
			r = 16'(rnd() % 20 + 30);
			setup(16'h0001, r, c0(2'(s), 1'b1), 8'h03);
			wr_reg(`IDX_CTL1, c1(1'b1, 1'b1, MODE_GATED, 3'h0));
			repeat (20) @(posedge clock_i);
			rd16(`IDX_CNT_HI, v1);
			check(v1, 16'h0001, "gate closed");
			k = r + rnd() % 10;
			lvl <= 1'b1;
			repeat (k) @(posedge clock_i);
			lvl <= 1'b0;
			repeat (10) @(posedge clock_i);
			rd16(`IDX_CNT_HI, v1);
			check(v1, steps(16'h0001, r, k), "gated count");
			d = (s == 1) ? 8'h02 : (s == 2) ? 8'h01 : 8'h03;
			rd_chk(`IDX_STAT, d, "gated status");
			check(16'(irq), 16'h1, "gated irq");
			check(16'(tin != 1'b1), 16'h1, "pin vs polarity");
			wr_reg(`IDX_STAT, 8'h03);
			@(posedge clock_i);
			check(16'(irq), 16'h0, "gated clear");
		end
		$display("Test gated done");
		// Capture: the first edge only starts, the second captures.
		for (int c = 0; c < 2; c++) begin
			lvl <= 1'b0;
			setup(16'h0001, 16'hffff, c0(2'h0, 1'b0), 8'h02);
			wr_reg(`IDX_CTL1, c1(1'b1, 1'b1, c ? MODE_CAPCMP :
				MODE_CAPTURE, 3'h0));
			p = rnd() % 50 + 20;
			a = p / 2;
			lvl <= 1'b1;
			repeat (a) @(posedge clock_i);
			lvl <= 1'b0;
			check(16'(irq), 16'h0, "first edge quiet");
			repeat (p - a) @(posedge clock_i);
			lvl <= 1'b1;
			repeat (10) @(posedge clock_i);
			check(16'(irq), 16'h1, "capture irq");
			rd16(`IDX_PWM_HI, v1);
			v1 = v1 - 16'h0001;
			check(16'(v1 == p || v1 == p - 1), 16'h1, "capture");
			wr_reg(`IDX_CTL1, 8'h00);
			wr_reg(`IDX_STAT, 8'h03);
		end
		$display("Test capture done");
		// PWM: output at polarity from reload until the match.
		for (int pol = 0; pol < 2; pol++) begin
			r = 16'(rnd() % 20 + 20);
			m = 16'(rnd() % (r - 5) + 3);
			setup(16'h0001, r, c0(2'h0, 1'b1), 8'h00);
			wr_reg(`IDX_PWM_HI, 8'h00);
			wr_reg(`IDX_PWM_LO, m[7:0]);
			wr_reg(`IDX_CTL1, c1(1'b1, 1'(pol), MODE_PWM, 3'h0));
			wait_out(~1'(pol), k);
			wait_out(1'(pol), k);
			wait_out(~1'(pol), k);
			check(16'(k), m, "pwm active time");
			wait_out(1'(pol), k);
			check(16'(k), r - m, "pwm idle time");
			wr_reg(`IDX_CTL1, 8'h00);
		end
		$display("Test pwm done");
		stop_test();
	end
endmodule
